/* File: inc/cior_consts.vh */
// How it works
// - command address 10000 or 10001 selects register
// - mode 00: sleep, bus wake ignored
// - mode 01: receive only, driver off
// - mode 10: sleep, wake to device or interrupt
// - mode 11: full transmit and receive
// - slew 00/11 fast, 01 medium, 10 slow
// - bit 3: three pulses or one pulse wake
// - fault bit 0: interrupt after five transmit pulses
// - fault bit 1: interrupt on first detection
// - first normal entry forces sleep with wake
// - pin 3: off, wake, high side twice
// - pin 2: off, wake, high side twice
// - pin 1: off, wake, low side, high side
// - pin 0: off, wake, low side, high side
// - reset clears whole pin register
`ifndef CIOR_CONSTS_VH
`define CIOR_CONSTS_VH

// ------------------------------------------------------------
// command word layout
// ------------------------------------------------------------
`define CIOR_KIND_HI        15
`define CIOR_KIND_LO        14
`define CIOR_ADDR_HI        13
`define CIOR_ADDR_LO        9
`define CIOR_CMD_WRITE      2'h1
`define CIOR_ADDR_CAN       5'h10
`define CIOR_ADDR_IO        5'h11

// ------------------------------------------------------------
// can control fields and reset values
// ------------------------------------------------------------
`define CIOR_MODE_HI        7
`define CIOR_MODE_LO        6
`define CIOR_SLEW_HI        5
`define CIOR_SLEW_LO        4
`define CIOR_WAKE_BIT       3
`define CIOR_FAULT_BIT      0
`define CIOR_CAN_MASK       8'hf9
`define CIOR_CAN_RESET      8'hc0
`define CIOR_IO_RESET       8'h00

// ------------------------------------------------------------
// mode and slew codes
// ------------------------------------------------------------
`define CIOR_MODE_SLEEP     2'h0
`define CIOR_MODE_RXONLY    2'h1
`define CIOR_MODE_WAKE      2'h2
`define CIOR_MODE_FULL      2'h3
`define CIOR_SLEW_FAST      2'h0
`define CIOR_SLEW_MEDIUM    2'h1
`define CIOR_SLEW_SLOW      2'h2

// ------------------------------------------------------------
// pulse counts
// ------------------------------------------------------------
`define CIOR_WAKE_MULTI     3'h3
`define CIOR_WAKE_SINGLE    3'h1
`define CIOR_FAULT_PULSES   3'h5

`endif

/* File: verification/can_and_io_pin_config_regs_bench.sv */
`timescale 1ns/100ps
`default_nettype none

module can_and_io_pin_config_regs_bench;
    typedef struct packed {logic [15:0] w; logic [8:0] rd; logic [17:0] e;} cior_row_t;

    logic        core_clk       = 1'b0; // device clock
    logic        reset          = 1'b1; // power-on reset
    logic        devNormal      = 1'b0; // device mode levels
    logic        devLowPower    = 1'b0;
    logic        canBusDominant = 1'b0; // bus idle recessive
    logic        transmitInput  = 1'b1;
    logic        busFaultPin    = 1'b0;
    logic [3:0]  ioPin          = 4'h0; // low until the pin wake test
    logic        cmdValid, readValid_r, canRxEnable_r, canTxEnable_r, canSleep_r;
    logic        canWakeEnable_r, canDevWake_r, canWakeInt_r, busFailInt_r;
    logic [15:0] cmdWord;
    logic [7:0]  readData_r, nDev = 8'h00, nInt = 8'h00, nFail = 8'h00;
    logic [1:0]  canSlew_r;
    logic [3:0]  highSideOn, lowSideOn, ioWakeEnable, ioWake, ioSeen = 4'h0;
    logic [8:0]  ans;
    int          nMismatch = 0, nChecks = 0;
    wire logic [17:0] obs = {canRxEnable_r, canTxEnable_r, canSleep_r, canWakeEnable_r,
                             canSlew_r, highSideOn, lowSideOn, ioWakeEnable};

    // ----------------------------------------
    // command word, readback, controls after the write has landed
    // ----------------------------------------
    cior_row_t rows [12] = '{
        '{16'h6000, 9'h1c0, 18'h08000}, '{16'h6050, 9'h100, 18'h21000},
        '{16'h60a0, 9'h150, 18'h0e000}, '{16'h60f6, 9'h1a0, 18'h30000},
        '{16'h6255, 9'h100, 18'h3000f}, '{16'h62aa, 9'h155, 18'h30c30},
        '{16'h62ff, 9'h1aa, 18'h30f00}, '{16'h621b, 9'h1ff, 18'h30124},
        '{16'h62e4, 9'h11b, 18'h30c02}, '{16'h6400, 9'h01b, 18'h30c02},
        '{16'ha0ff, 9'h1f0, 18'h30c02}, '{16'h2200, 9'h1e4, 18'h30c02}};

    cior_host_model i_cior_host_model (.core_clk, .readValid_r, .readData_r, .cmdValid,
        .cmdWord);
    cior_regs i_cior_regs (.core_clk, .reset, .cmdValid, .cmdWord, .readValid_r,
        .readData_r, .devNormal, .devLowPower, .canBusDominant, .transmitInput, .busFaultPin,
        .canRxEnable_r, .canTxEnable_r, .canSleep_r, .canWakeEnable_r, .canSlew_r,
        .canDevWake_r, .canWakeInt_r, .busFailInt_r, .ioPin, .highSideOn, .lowSideOn,
        .ioWakeEnable, .ioWake);

    initial forever #4 core_clk = ~core_clk;

    // can event pulses are counted, so a pulse longer than one cycle shows up
    always @(posedge core_clk)
    begin
        nDev  <= nDev + canDevWake_r;
        nInt  <= nInt + canWakeInt_r;
        nFail <= nFail + busFailInt_r;
        ioSeen <= ioSeen | ioWake;
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        nChecks++;
        if (got !== exp)
        begin
            nMismatch++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic close_out;
        $display("checks=%0d mismatches=%0d", nChecks, nMismatch);
        if (nMismatch == 0 && nChecks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    // write, then let the controls settle one edge after the taken edge
    task automatic wr(input logic [15:0] w);
        i_cior_host_model.xfer(w, ans);
        @(posedge core_clk);
        #1;
    endtask

    // n dominant pulses on the bus, or on the transmit input when tx is set
    task automatic pulse(input int n, input logic tx);
        repeat (n)
        begin
            @(posedge core_clk);
            {canBusDominant, transmitInput} <= tx ? 2'b00 : 2'b11;
            repeat (4) @(posedge core_clk);
            {canBusDominant, transmitInput} <= 2'b01;
            repeat (4) @(posedge core_clk);
        end
        repeat (12) @(posedge core_clk);
        #1;
    endtask

    // watchdog at about eighteen times the length of a clean run
    initial
    begin
        #40000;
        nMismatch++;
        close_out;
    end

    initial
    begin
        repeat (8) @(posedge core_clk);
        reset <= 1'b0;
        chk(obs, 18'h30000);
        foreach (rows[k])
        begin
            wr(rows[k].w);
            chk(ans, rows[k].rd);
            chk(obs, rows[k].e);
        end
        // first normal stay forced asleep, later stays follow the field
        for (int k = 0; k < 3; k++)
        begin
            @(posedge core_clk);
            devNormal <= !k[0];
            repeat (3) @(posedge core_clk);
            #1 chk(obs, k ? 18'h30c02 : 18'h0cc02);
        end
        @(posedge core_clk);
        {devNormal, devLowPower} <= 2'b01;
        wr(16'h6088);
        pulse(1, 1'b0);
        chk({nDev, nInt, nFail}, 24'h010000);
        wr(16'h6008);
        pulse(1, 1'b0);
        chk({nDev, nInt, nFail}, 24'h010000);
        @(posedge core_clk) {devNormal, devLowPower} <= 2'b10;
        wr(16'h6080);
        pulse(2, 1'b0);
        chk({nDev, nInt, nFail}, 24'h010000);
        pulse(1, 1'b0);
        chk({nDev, nInt, nFail}, 24'h010100);
        wr(16'h60c1);
        @(posedge core_clk) busFaultPin <= 1'b1;
        pulse(0, 1'b0);
        chk({nDev, nInt, nFail}, 24'h010101);
        @(posedge core_clk) busFaultPin <= 1'b0;
        wr(16'h60c0);
        @(posedge core_clk) busFaultPin <= 1'b1;
        pulse(0, 1'b0);
        pulse(4, 1'b1);
        chk({nDev, nInt, nFail}, 24'h010101);
        pulse(1, 1'b1);
        chk({nDev, nInt, nFail}, 24'h010102);
        // pins rise together; only pin 1 is set to wake
        @(posedge core_clk) ioPin <= 4'hf;
        pulse(0, 1'b0);
        chk(ioSeen, 4'h2);
        // power-on reset mid-run; normal mode stays high across it
        @(posedge core_clk) reset <= 1'b1;
        #1 chk(obs, 18'h30000);
        @(posedge core_clk) reset <= 1'b0;
        wr(16'ha000);
        chk(ans, 9'h1c0);
        wr(16'h2200);
        chk(ans, 9'h100);
        chk(obs, 18'h0c000);
        close_out;
    end
endmodule // can_and_io_pin_config_regs_bench

`default_nettype wire

/* File: verification/cior_host_model.sv */
`timescale 1ns/100ps
`default_nettype none

// ----------------------------------------
// host side of the command port
// ----------------------------------------
module cior_host_model
(
    input  wire logic        core_clk,    // device clock
    input  wire logic        readValid_r, // answer strobe
    input  wire logic [7:0]  readData_r,  // readback
    output var  logic        cmdValid,    // command strobe
    output var  logic [15:0] cmdWord      // command word
);
    // idle port at time zero
    initial
    begin
        cmdValid = 1'b0;
        cmdWord  = 16'h0000;
    end

    // one command; the answer is taken once the taken edge has landed
    task automatic xfer(input logic [15:0] w, output logic [8:0] ans);
        @(posedge core_clk);
        cmdValid <= 1'b1;
        cmdWord  <= w;
        @(posedge core_clk);
        cmdValid <= 1'b0;
        cmdWord  <= ~w; // a released word must not look like the last one
        #1 ans = {readValid_r, readData_r};
    endtask
endmodule // cior_host_model

`default_nettype wire

/* File: verification/cior_regs_assertions.sv */
`timescale 1ns/100ps
`default_nettype none

// ----------------------------------------
// checker on the register block ports
// ----------------------------------------
module cior_regs_assertions
(
    input wire logic        core_clk,        // clock
    input wire logic        reset,           // async reset
    input wire logic        cmdValid,        // strobe
    input wire logic [15:0] cmdWord,         // command
    input wire logic        readValid_r,     // answer
    input wire logic [7:0]  readData_r,      // readback
    input wire logic        devNormal,       // normal mode
    input wire logic        canRxEnable_r,   // rx on
    input wire logic        canTxEnable_r,   // tx on
    input wire logic        canSleep_r,      // asleep
    input wire logic        canWakeEnable_r, // wake armed
    input wire logic [1:0]  canSlew_r,       // slew
    input wire logic [3:0]  highSideOn,      // high side
    input wire logic [3:0]  lowSideOn,       // low side
    input wire logic [3:0]  ioWakeEnable     // wake inputs
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (reset);

    logic left_r;                                  // first normal stay is over
    wire  hit = cmdValid && cmdWord[13:10] == 4'h8; // address 10000 or 10001

    // remember the end of the first normal stay; later stays obey the field
    always @(posedge core_clk or posedge reset)
    begin
        if (reset)
            left_r <= 1'b0;
        else if ($fell(devNormal))
            left_r <= 1'b1;
    end

    AST_ANSWER: assert property (hit |=> readValid_r)
        else $error("mapped command got no readback");
    AST_REFUSE: assert property (!hit |=> !readValid_r)
        else $error("readback without a mapped command");
    AST_ZERO_BITS: assert property (hit && !cmdWord[9] |=> readData_r[2:1] == 2'h0)
        else $error("unused can bits read nonzero");
    AST_FULL: assert property (canTxEnable_r |-> canRxEnable_r && !canSleep_r)
        else $error("driver on without receiver");
    AST_SLEEP: assert property (canSleep_r |-> !canRxEnable_r && !canTxEnable_r)
        else $error("sleeping interface still active");
    AST_WAKE: assert property (canWakeEnable_r |-> canSleep_r)
        else $error("wake armed while awake");
    AST_SLEW: assert property (canSlew_r != 2'h3)
        else $error("illegal slew code");
    AST_FIRST: assert property (devNormal && !left_r ##2 devNormal && !left_r
        |-> canSleep_r && canWakeEnable_r)
        else $error("first normal stay not forced asleep");
    AST_IO_HS: assert property (hit && cmdWord[15:9] == 7'h31 && cmdWord[1:0] == 2'h3
        |-> ##2 highSideOn[0])
        else $error("pin 0 high side not enabled");
    AST_IO_MAP: assert property ((highSideOn & lowSideOn) == 4'h0
        && lowSideOn[3:2] == 2'h0 && (ioWakeEnable & (highSideOn | lowSideOn)) == 4'h0)
        else $error("pin drivers and wake overlap");
endmodule // cior_regs_assertions

bind cior_regs cior_regs_assertions i_cior_regs_assertions (.core_clk, .reset, .cmdValid,
    .cmdWord, .readValid_r, .readData_r, .devNormal, .canRxEnable_r, .canTxEnable_r,
    .canSleep_r, .canWakeEnable_r, .canSlew_r, .highSideOn, .lowSideOn, .ioWakeEnable);

`default_nettype wire

/* File: verilog/cior_io_decode.v */
`timescale 1ns/100ps
`default_nettype none

module cior_io_decode
(
    input  wire       core_clk,     // device clock
    input  wire       reset,        // async reset, high
    input  wire [7:0] ioField,      // pin control register
    input  wire [3:0] ioPin,        // raw pin levels
    output reg  [3:0] highSideOn_r, // high_side_driver enables
    output reg  [3:0] lowSideOn_r,  // low_side_driver enables
    output reg  [3:0] wakeEnable_r, // wake input enables
    output reg  [3:0] ioWake_r      // one-cycle wake per pin
);

    // returns {high, low, wake}; pins without a low side map 10 to high
    function [2:0] pinDecode;
        input [1:0] code;
        input       hasLow;
        begin
            case (code)
                2'h0:    pinDecode = 3'h0;
                2'h1:    pinDecode = 3'h1;
                2'h2:    pinDecode = hasLow ? 3'h2 : 3'h4;
                default: pinDecode = 3'h4;
            endcase
        end
    endfunction

    genvar i;
    generate
        for (i = 0; i < 4; i = i + 1)
        begin : gPin
            reg        s1_r;
            reg        s2_r;
            reg        s3_r;
            reg        stable_r;
            wire [2:0] dec;
            // pins 0 and 1 own a low side; 2 and 3 do not
            assign dec = pinDecode(ioField[2*i+1:2*i], (i < 2) ? 1'b1 : 1'b0);

            always @(posedge core_clk or posedge reset)
            begin
                if (reset)
                begin
                    s1_r            <= 1'b0;
                    s2_r            <= 1'b0;
                    s3_r            <= 1'b0;
                    stable_r        <= 1'b0;
                    highSideOn_r[i] <= 1'b0;
                    lowSideOn_r[i]  <= 1'b0;
                    wakeEnable_r[i] <= 1'b0;
                    ioWake_r[i]     <= 1'b0;
                end
                else
                begin
                    s1_r            <= ioPin[i];
                    s2_r            <= s1_r;
                    s3_r            <= s2_r;
                    highSideOn_r[i] <= dec[2];
                    lowSideOn_r[i]  <= dec[1];
                    wakeEnable_r[i] <= dec[0];
                    ioWake_r[i]     <= 1'b0;
                    // either transition wakes, only while wake is enabled
                    if (s2_r == s3_r && s3_r != stable_r)
                    begin
                        stable_r    <= s3_r;
                        ioWake_r[i] <= dec[0];
                    end
                end
            end
        end
    endgenerate

endmodule // cior_io_decode

`default_nettype wire

/* File: verilog/cior_pulse_count.v */
`timescale 1ns/100ps
`default_nettype none

module cior_pulse_count
(
    input  wire       core_clk,    // device clock
    input  wire       reset,       // async reset, high
    input  wire       pinIn,       // raw pin
    input  wire       activeLow,   // pin asserts low
    input  wire       enable,      // count only while high
    input  wire [2:0] target,      // pulses needed
    output reg        hit_r        // one-cycle pulse on target
);

    reg       sync1_r;
    reg       sync2_r;
    reg       sync3_r;
    reg       stable_r;
    reg [2:0] count_r;
    wire      level;

    // -------------------------------------------------------
    // three-stage synchroniser, level taken when stages 2 and 3 agree
    // -------------------------------------------------------
    always @(posedge core_clk or posedge reset)
    begin
        if (reset)
        begin
            sync1_r  <= 1'b0;
            sync2_r  <= 1'b0;
            sync3_r  <= 1'b0;
            stable_r <= 1'b0;
        end
        else
        begin
            sync1_r <= pinIn;
            sync2_r <= sync1_r;
            sync3_r <= sync2_r;
            if (sync2_r == sync3_r)
                stable_r <= sync3_r;
        end
    end

    assign level = (sync2_r == sync3_r) ? (sync3_r ^ activeLow) : (stable_r ^ activeLow);

    // -------------------------------------------------------
    // count asserting edges; disable clears partial progress
    // -------------------------------------------------------
    always @(posedge core_clk or posedge reset)
    begin
        if (reset)
        begin
            count_r <= 3'h0;
            hit_r   <= 1'b0;
        end
        else
        begin
            hit_r <= 1'b0;
            if (!enable)
                count_r <= 3'h0;
            else if (level && !(stable_r ^ activeLow))
            begin
                if (count_r + 3'h1 >= target)
                begin
                    count_r <= 3'h0;
                    hit_r   <= 1'b1;
                end
                else
                    count_r <= count_r + 3'h1;
            end
        end
    end

endmodule // cior_pulse_count

`default_nettype wire

/* File: verilog/cior_regs.v */
`timescale 1ns/100ps
`default_nettype none
`include "cior_consts.vh"

module cior_regs
(
    input  wire        core_clk,        // 125 MHz device clock
    input  wire        reset,           // power-on reset, async, high
    // command port from the serial front end
    input  wire        cmdValid,        // one-cycle command strobe
    input  wire [15:0] cmdWord,         // kind, address, parity, data
    output reg         readValid_r,     // one-cycle readback strobe
    output reg  [7:0]  readData_r,      // register content
    // device state
    input  wire        devNormal,       // device in normal mode
    input  wire        devLowPower,     // device in low_power mode
    // can pins
    input  wire        canBusDominant,  // bus dominant, high active
    input  wire        transmitInput,   // transmit_input pin, low dominant
    input  wire        busFaultPin,     // bus failure detector
    // can controls
    output reg         canRxEnable_r,   // receiver on
    output reg         canTxEnable_r,   // transmit driver on
    output reg         canSleep_r,      // interface asleep
    output reg         canWakeEnable_r, // bus wake armed
    output reg  [1:0]  canSlew_r,       // fast, medium or slow
    output reg         canDevWake_r,    // wake pulse in low_power
    output reg         canWakeInt_r,    // wake interrupt pulse
    output reg         busFailInt_r,    // bus failure interrupt pulse
    // io pins
    input  wire [3:0]  ioPin,           // raw pin levels
    output wire [3:0]  highSideOn,      // high_side_driver enables
    output wire [3:0]  lowSideOn,       // low_side_driver enables
    output wire [3:0]  ioWakeEnable,    // wake input enables
    output wire [3:0]  ioWake           // wake pulse per pin
);

    // --------------------------------------------------------
    // register storage
    // --------------------------------------------------------
    reg  [7:0] canCtrl_r;
    reg  [7:0] ioCtrl_r;
    reg        normalSeen_r;
    reg        firstStay_r;
    reg        prevNormal_r;
    reg        faultSync1_r;
    reg        faultSync2_r;
    reg        faultSync3_r;
    reg        faultStable_r;
    reg        faultRaised_r;

    wire [4:0] cmdAddr;
    wire       cmdWrite;
    wire       hitCan;
    wire       hitIo;
    wire [1:0] modeField;
    wire [1:0] effMode;
    wire       wakeSingle;
    wire       faultEarly;
    wire       wakeHit;
    wire       faultHit;
    wire       normalRise;
    wire       faultNow;
    wire       faultRise;

    // --------------------------------------------------------
    // command decode
    // --------------------------------------------------------
    assign cmdAddr  = cmdWord[`CIOR_ADDR_HI:`CIOR_ADDR_LO];
    assign cmdWrite = cmdWord[`CIOR_KIND_HI:`CIOR_KIND_LO] == `CIOR_CMD_WRITE;
    assign hitCan   = cmdValid && (cmdAddr == `CIOR_ADDR_CAN);
    assign hitIo    = cmdValid && (cmdAddr == `CIOR_ADDR_IO);

    // --------------------------------------------------------
    // writable registers
    // --------------------------------------------------------
    // unused can bits are masked on the way in so they never read back
    always @(posedge core_clk or posedge reset)
    begin
        if (reset)
        begin
            canCtrl_r <= `CIOR_CAN_RESET;
            ioCtrl_r  <= `CIOR_IO_RESET;
        end
        else
        begin
            if (hitCan && cmdWrite)
                canCtrl_r <= cmdWord[7:0] & `CIOR_CAN_MASK;
            if (hitIo && cmdWrite)
                ioCtrl_r <= cmdWord[7:0];
        end
    end

    // --------------------------------------------------------
    // readback
    // --------------------------------------------------------
    // any command to a known address answers with the content it
    // held before that command, one cycle later
    always @(posedge core_clk or posedge reset)
    begin
        if (reset)
        begin
            readValid_r <= 1'b0;
            readData_r  <= 8'h00;
        end
        else
        begin
            readValid_r <= hitCan || hitIo;
            if (hitCan)
                readData_r <= canCtrl_r & `CIOR_CAN_MASK;
            else if (hitIo)
                readData_r <= ioCtrl_r;
        end
    end

    // --------------------------------------------------------
    // first entry into normal mode
    // --------------------------------------------------------
    assign normalRise = devNormal && !prevNormal_r;

    // the override holds for the whole first stay in normal mode and
    // is dropped for good when the device leaves it
    always @(posedge core_clk or posedge reset)
    begin
        if (reset)
        begin
            prevNormal_r <= 1'b0;
            normalSeen_r <= 1'b0;
            firstStay_r  <= 1'b0;
        end
        else
        begin
            prevNormal_r <= devNormal;
            if (normalRise && !normalSeen_r)
            begin
                normalSeen_r <= 1'b1;
                firstStay_r  <= 1'b1;
            end
            else if (!devNormal)
                firstStay_r <= 1'b0;
        end
    end

    // --------------------------------------------------------
    // effective can settings
    // --------------------------------------------------------
    assign modeField  = canCtrl_r[`CIOR_MODE_HI:`CIOR_MODE_LO];
    assign effMode    = (firstStay_r || (normalRise && !normalSeen_r)) ?
                        `CIOR_MODE_WAKE : modeField;
    assign wakeSingle = canCtrl_r[`CIOR_WAKE_BIT];
    assign faultEarly = canCtrl_r[`CIOR_FAULT_BIT];

    // slew decode; 11 folds onto fast
    function [1:0] slewDecode;
        input [1:0] code;
        begin
            case (code)
                2'h1:    slewDecode = `CIOR_SLEW_MEDIUM;
                2'h2:    slewDecode = `CIOR_SLEW_SLOW;
                default: slewDecode = `CIOR_SLEW_FAST;
            endcase
        end
    endfunction

    // --------------------------------------------------------
    // can interface controls
    // --------------------------------------------------------
    always @(posedge core_clk or posedge reset)
    begin
        if (reset)
        begin
            canRxEnable_r   <= 1'b1;
            canTxEnable_r   <= 1'b1;
            canSleep_r      <= 1'b0;
            canWakeEnable_r <= 1'b0;
            canSlew_r       <= `CIOR_SLEW_FAST;
        end
        else
        begin
            canSlew_r <= slewDecode(canCtrl_r[`CIOR_SLEW_HI:`CIOR_SLEW_LO]);
            case (effMode)
                `CIOR_MODE_SLEEP:
                begin
                    canRxEnable_r   <= 1'b0;
                    canTxEnable_r   <= 1'b0;
                    canSleep_r      <= 1'b1;
                    canWakeEnable_r <= 1'b0;
                end
                `CIOR_MODE_RXONLY:
                begin
                    canRxEnable_r   <= 1'b1;
                    canTxEnable_r   <= 1'b0;
                    canSleep_r      <= 1'b0;
                    canWakeEnable_r <= 1'b0;
                end
                `CIOR_MODE_WAKE:
                begin
                    canRxEnable_r   <= 1'b0;
                    canTxEnable_r   <= 1'b0;
                    canSleep_r      <= 1'b1;
                    canWakeEnable_r <= 1'b1;
                end
                default:
                begin
                    canRxEnable_r   <= 1'b1;
                    canTxEnable_r   <= 1'b1;
                    canSleep_r      <= 1'b0;
                    canWakeEnable_r <= 1'b0;
                end
            endcase
        end
    end

    // --------------------------------------------------------
    // bus wake detection
    // --------------------------------------------------------
    // counter runs only while wake is armed, so mode 00 never wakes
    cior_pulse_count uWake
    (
        .core_clk  (core_clk),
        .reset     (reset),
        .pinIn     (canBusDominant),
        .activeLow (1'b0),
        .enable    (canWakeEnable_r),
        .target    (wakeSingle ? `CIOR_WAKE_SINGLE : `CIOR_WAKE_MULTI),
        .hit_r     (wakeHit)
    );

    // route a wake by the device state at the moment it is seen
    always @(posedge core_clk or posedge reset)
    begin
        if (reset)
        begin
            canDevWake_r <= 1'b0;
            canWakeInt_r <= 1'b0;
        end
        else
        begin
            canDevWake_r <= wakeHit && devLowPower;
            canWakeInt_r <= wakeHit && devNormal;
        end
    end

    // --------------------------------------------------------
    // bus failure detection
    // --------------------------------------------------------
    // detector output is asynchronous, three stages and agreement
    always @(posedge core_clk or posedge reset)
    begin
        if (reset)
        begin
            faultSync1_r  <= 1'b0;
            faultSync2_r  <= 1'b0;
            faultSync3_r  <= 1'b0;
            faultStable_r <= 1'b0;
        end
        else
        begin
            faultSync1_r <= busFaultPin;
            faultSync2_r <= faultSync1_r;
            faultSync3_r <= faultSync2_r;
            if (faultSync2_r == faultSync3_r)
                faultStable_r <= faultSync3_r;
        end
    end

    assign faultNow  = (faultSync2_r == faultSync3_r) ? faultSync3_r : faultStable_r;
    assign faultRise = faultNow && !faultStable_r;

    // identification waits for dominant pulses on the transmit input
    cior_pulse_count uFault
    (
        .core_clk  (core_clk),
        .reset     (reset),
        .pinIn     (transmitInput),
        .activeLow (1'b1),
        .enable    (faultStable_r && !faultRaised_r),
        .target    (`CIOR_FAULT_PULSES),
        .hit_r     (faultHit)
    );

    // one interrupt per failure episode; a new episode needs the
    // failure to clear first, which avoids a stream of interrupts
    always @(posedge core_clk or posedge reset)
    begin
        if (reset)
        begin
            busFailInt_r  <= 1'b0;
            faultRaised_r <= 1'b0;
        end
        else
        begin
            busFailInt_r <= 1'b0;
            if (!faultRaised_r && faultEarly && faultRise)
            begin
                busFailInt_r  <= 1'b1;
                faultRaised_r <= 1'b1;
            end
            else if (!faultRaised_r && !faultEarly && faultHit)
            begin
                busFailInt_r  <= 1'b1;
                faultRaised_r <= 1'b1;
            end
            else if (!faultStable_r && !faultNow)
                faultRaised_r <= 1'b0;
        end
    end

    // --------------------------------------------------------
    // io pin configuration
    // --------------------------------------------------------
    cior_io_decode uIo
    (
        .core_clk     (core_clk),
        .reset        (reset),
        .ioField      (ioCtrl_r),
        .ioPin        (ioPin),
        .highSideOn_r (highSideOn),
        .lowSideOn_r  (lowSideOn),
        .wakeEnable_r (ioWakeEnable),
        .ioWake_r     (ioWake)
    );

endmodule // cior_regs

`default_nettype wire
